// ### common/cpb_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CPB_MAP_SVH
`define CPB_MAP_SVH
`define CPB_OFS_OPT3        8'h37
`define CPB_OFS_PHOT0       8'h3c
`define CPB_BIT_OC_EN       10
`define CPB_BIT_OC_LVL      9
`define CPB_BIT_HS_TH       7
`define CPB_BIT_LS_TH       6
`define CPB_BIT_FL_TH       5
`define CPB_BIT_RT_HI       4
`define CPB_BIT_RT_LO       3
`define CPB_BIT_BOOST_EN    2
`define CPB_BIT_BOOST_STAT  1
`define CPB_BIT_CRIT_HI     15
`define CPB_BIT_CRIT_LO     11
`define CPB_OPT3_WMASK      16'h06fc
`define CPB_OPT3_RST        16'h0240
`define CPB_PHOT0_WMASK     16'hfefe
`define CPB_PHOT0_RST       16'h4a56
`define CPB_CLK_MHZ         20
`define CPB_RT_150_US       150
`define CPB_RT_250_US       250
`define CPB_RT_50_US        50
`define CPB_RT_150_CYC      (`CPB_RT_150_US * `CPB_CLK_MHZ)
`define CPB_RT_250_CYC      (`CPB_RT_250_US * `CPB_CLK_MHZ)
`define CPB_RT_50_CYC       (`CPB_RT_50_US * `CPB_CLK_MHZ)
`define CPB_MIN_LIMIT_MA    1536
`endif

// ### common/cpb_pkg.sv
// Types for the charger protection and boost configuration block
`default_nettype none
package cpb_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cpb_req_t;
  typedef enum logic [1:0] {
    CPB_IDLE  = 2'b00,
    CPB_WAIT  = 2'b01,
    CPB_BOOST = 2'b10
  } cpb_state_t;
endpackage
`default_nettype wire

// ### hw/cpb_config.sv
// Protection and boost option registers with boost entry sequencing
// Function
// - Bit 10 enables input over-current protection
// - Bit 7 enables high-side short at 750mV
// - Bit 6 enables low-side short at 250mV
// - Low-side threshold limits current in boost
// - Bit 5 picks fast limit comparator threshold
// - Bits 4:3 pick boost response delay
// - Bit 2 enables boost mode
// - Battery removal clears boost enable
// - Bit 1 reads boost status
// - Critical level five bits drives trip level
`timescale 1ns/1ns
`default_nettype none
`include "cpb_map.svh"
module cpb_config
  import cpb_pkg::*;
#(
  parameter int unsigned RT150_CYC = `CPB_RT_150_CYC,
  parameter int unsigned RT250_CYC = `CPB_RT_250_CYC,
  parameter int unsigned RT50_CYC  = `CPB_RT_50_CYC
)(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire cpb_req_t    req,
  output var  logic [15:0] rdata,
  output var  logic        rvalid,
  input  wire logic        battery_present_n,
  input  wire logic        fast_limit_over,
  output var  logic        input_overcurrent_enable,
  output var  logic        input_overcurrent_level,
  output var  logic [4:0]  critical_current_level,
  output var  logic        high_side_short_threshold,
  output var  logic        low_side_short_threshold,
  output var  logic        cycle_limit_enable,
  output var  logic        fast_limit_threshold,
  output var  logic        boost_active
);
  logic [15:0] opt3_r;
  logic [15:0] phot0_r;
  logic [15:0] rdata_r;
  logic        rvalid_r;
  logic [2:0]  bp_sync_r;
  logic [1:0]  fl_sync_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  cpb_state_t  st_r;
  cpb_state_t  st_nxt;
  logic        oc_en_r;
  logic        oc_lvl_r;
  logic [4:0]  crit_r;
  logic        hs_r;
  logic        ls_r;
  logic        cyc_r;
  logic        flth_r;
  logic        bst_r;
  logic [15:0] wait_len_r;
  logic [1:0]  wait_sel_r;
  logic [15:0] wait_exp;
  // Reset images of the two registers, used to seed the field outputs
  localparam logic [15:0] OPT3_RST  = `CPB_OPT3_RST;
  localparam logic [15:0] PHOT0_RST = `CPB_PHOT0_RST;

  function automatic logic [15:0] resp_cycles(input logic [1:0] sel);
    if (sel[1])
      resp_cycles = 16'(RT50_CYC);
    else if (sel[0])
      resp_cycles = 16'(RT250_CYC);
    else
      resp_cycles = 16'(RT150_CYC);
  endfunction

  wire        wr_opt3   = req.wr && (req.addr == `CPB_OFS_OPT3);
  wire        wr_phot0  = req.wr && (req.addr == `CPB_OFS_PHOT0);
  wire        sel_opt3  = req.addr == `CPB_OFS_OPT3;
  wire        sel_phot0 = req.addr == `CPB_OFS_PHOT0;
  // Battery pulled: sync level went from low (present) to high
  wire        bat_removed = bp_sync_r[1] && !bp_sync_r[2];
  wire        fl_over   = fl_sync_r[1];
  wire [15:0] opt3_wr_val = (opt3_r & ~`CPB_OPT3_WMASK) | (req.wdata & `CPB_OPT3_WMASK);
  wire [15:0] opt3_base   = wr_opt3 ? opt3_wr_val : opt3_r;
  // Removal wins over a same-cycle host write setting the enable
  wire [15:0] opt3_nxt    = bat_removed ? (opt3_base & ~(16'h1 << `CPB_BIT_BOOST_EN)) : opt3_base;
  wire        boost_en    = opt3_r[`CPB_BIT_BOOST_EN];
  wire        in_boost    = st_r == CPB_BOOST;
  wire [15:0] stat_word   = 16'(in_boost) << `CPB_BIT_BOOST_STAT;
  wire [15:0] opt3_rd     = (opt3_r & `CPB_OPT3_WMASK) | stat_word;
  wire [15:0] phot0_rd    = phot0_r & `CPB_PHOT0_WMASK;
  wire [15:0] rd_val      = sel_opt3 ? opt3_rd : (sel_phot0 ? phot0_rd : 16'h0000);

  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      CPB_IDLE:
        if (boost_en && fl_over)
        begin
          st_nxt  = CPB_WAIT;
          cnt_nxt = resp_cycles(opt3_r[`CPB_BIT_RT_HI:`CPB_BIT_RT_LO]);
        end
      CPB_WAIT:
        if (!boost_en || !fl_over)
          st_nxt = CPB_IDLE;
        else if (cnt_r <= 16'h0001)
          st_nxt = CPB_BOOST;
        else
          cnt_nxt = cnt_r - 16'h0001;
      CPB_BOOST:
        if (!boost_en || !fl_over)
          st_nxt = CPB_IDLE;
      default:
        st_nxt = CPB_IDLE;
    endcase
  end

  // Option three: host write merged under the mask, then removal clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      opt3_r <= `CPB_OPT3_RST;
    else
      opt3_r <= opt3_nxt;
  end

  // Processor-hot option zero keeps only its writable bits
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      phot0_r <= `CPB_PHOT0_RST;
    else if (wr_phot0)
      phot0_r <= req.wdata & `CPB_PHOT0_WMASK;
  end

  // Pin synchronisers; a battery pulled during reset clears the enable on the third cycle after release, including an enable written in those three cycles
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bp_sync_r <= 3'b000;
      fl_sync_r <= 2'b00;
    end
    else
    begin
      bp_sync_r <= {bp_sync_r[1:0], battery_present_n};
      fl_sync_r <= {fl_sync_r[0], fast_limit_over};
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_r  <= CPB_IDLE;
      cnt_r <= 16'h0000;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Read data is captured with the request and stands until the next read
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= req.rd ? rd_val : rdata_r;
      rvalid_r <= req.rd;
    end
  end

  // Field outputs mirror the option bits one cycle later
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      oc_en_r  <= OPT3_RST[`CPB_BIT_OC_EN];
      oc_lvl_r <= OPT3_RST[`CPB_BIT_OC_LVL];
      crit_r   <= PHOT0_RST[`CPB_BIT_CRIT_HI:`CPB_BIT_CRIT_LO];
      hs_r     <= OPT3_RST[`CPB_BIT_HS_TH];
      ls_r     <= OPT3_RST[`CPB_BIT_LS_TH];
      flth_r   <= OPT3_RST[`CPB_BIT_FL_TH];
    end
    else
    begin
      oc_en_r  <= opt3_r[`CPB_BIT_OC_EN];
      oc_lvl_r <= opt3_r[`CPB_BIT_OC_LVL];
      crit_r   <= phot0_r[`CPB_BIT_CRIT_HI:`CPB_BIT_CRIT_LO];
      hs_r     <= opt3_r[`CPB_BIT_HS_TH];
      ls_r     <= opt3_r[`CPB_BIT_LS_TH];
      flth_r   <= opt3_r[`CPB_BIT_FL_TH];
    end
  end

  // Boost flags follow the sequencer state
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cyc_r <= 1'b0;
      bst_r <= 1'b0;
    end
    else
    begin
      cyc_r <= opt3_r[`CPB_BIT_LS_TH] && in_boost;
      bst_r <= in_boost;
    end
  end

  assign rdata                     = rdata_r;
  assign rvalid                    = rvalid_r;
  assign input_overcurrent_enable  = oc_en_r;
  assign input_overcurrent_level   = oc_lvl_r;
  assign critical_current_level    = crit_r;
  assign high_side_short_threshold = hs_r;
  assign low_side_short_threshold  = ls_r;
  assign cycle_limit_enable        = cyc_r;
  assign fast_limit_threshold      = flth_r;
  assign boost_active              = bst_r;

  // Checking aid: cycles spent waiting and the response code latched on entry
  always_ff @(posedge clock)
  begin
    if (!rst_n || st_r != CPB_WAIT)
      wait_len_r <= 16'h0000;
    else
      wait_len_r <= wait_len_r + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wait_sel_r <= 2'b00;
    else if (st_r == CPB_IDLE && st_nxt == CPB_WAIT)
      wait_sel_r <= opt3_r[`CPB_BIT_RT_HI:`CPB_BIT_RT_LO];
  end

  assign wait_exp = wait_sel_r[1] ? 16'(RT50_CYC) : (wait_sel_r[0] ? 16'(RT250_CYC) : 16'(RT150_CYC));

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  removal_clears_a: assert property (bat_removed |=> !opt3_r[`CPB_BIT_BOOST_EN])
    else $error("boost enable not cleared on battery removal");
  boost_needs_en_a: assert property (!boost_en |=> (st_r != CPB_BOOST))
    else $error("boost without enable");
  status_read_a: assert property (req.rd && sel_opt3 |=> rdata[`CPB_BIT_BOOST_STAT] == $past(st_r == CPB_BOOST))
    else $error("boost status read mismatch");
  reserved_zero_a: assert property (rvalid && $past(sel_opt3) |-> (rdata & ~`CPB_OPT3_WMASK & 16'hfffd) == 16'h0)
    else $error("reserved bits read nonzero");
  oc_follow_a: assert property (##1 input_overcurrent_enable == $past(opt3_r[`CPB_BIT_OC_EN]))
    else $error("overcurrent enable mismatch");
  lvl_follow_a: assert property (##1 input_overcurrent_level == $past(opt3_r[`CPB_BIT_OC_LVL]))
    else $error("overcurrent level mismatch");
  hs_follow_a: assert property (##1 high_side_short_threshold == $past(opt3_r[`CPB_BIT_HS_TH]))
    else $error("high side mismatch");
  cyc_limit_a: assert property (cycle_limit_enable |-> $past(st_r == CPB_BOOST) && low_side_short_threshold)
    else $error("cycle limit outside boost");
  wait_min_a: assert property ($rose(st_r == CPB_BOOST) |-> $past(st_r == CPB_WAIT))
    else $error("boost entered without response delay");

  // Field mirrors and register masks
  ls_follow_a: assert property (##1 low_side_short_threshold == $past(opt3_r[`CPB_BIT_LS_TH]))
    else $error("low side mismatch");
  flth_follow_a: assert property (##1 fast_limit_threshold == $past(opt3_r[`CPB_BIT_FL_TH]))
    else $error("fast limit threshold mismatch");
  crit_follow_a: assert property (##1 critical_current_level == $past(phot0_r[15:11]))
    else $error("critical level mismatch");
  opt3_mask_a: assert property ((opt3_r & ~`CPB_OPT3_WMASK) == 16'h0000)
    else $error("option three holds a read-only bit");
  phot0_mask_a: assert property ((phot0_r & ~`CPB_PHOT0_WMASK) == 16'h0000)
    else $error("option zero holds a reserved bit");
  // Sequencer and read valid checks
  act_follow_a: assert property (##1 boost_active == $past(st_r == CPB_BOOST))
    else $error("boost active mismatch");
  rvalid_pulse_a: assert property (req.rd |=> rvalid)
    else $error("read valid missing");
  wait_entry_a: assert property ($rose(st_r == CPB_WAIT) |-> $past(boost_en && fl_over))
    else $error("wait entered without enable and trigger");
  wait_length_a: assert property ($rose(st_r == CPB_BOOST) |-> wait_len_r == wait_exp)
    else $error("response delay length wrong");

  boost_enter_c: cover property ($rose(st_r == CPB_BOOST));
  boost_exit_c: cover property ($fell(st_r == CPB_BOOST));
  fast_resp_c: cover property ($rose(st_r == CPB_BOOST) && wait_sel_r[1]);
  removal_c: cover property (bat_removed && boost_en);
  wait_abort_c: cover property ((st_r == CPB_WAIT) ##1 (st_r == CPB_IDLE));
endmodule
`default_nettype wire

// ### sim/cpb_host.sv
// Host model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module cpb_host
  import cpb_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rvalid,
  input  wire logic [15:0] rdata,
  output var  cpb_req_t    req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge clock);
    req = '0;
    for (int i = 0; i < 4 && rvalid !== 1'b1; i++)
      @(negedge clock);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ### sim/cpb_config_tb_top.sv
// Self-checking bench for the protection and boost option block
`timescale 1ns/1ns
`default_nettype none
module cpb_config_tb_top
  import cpb_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        battery_present_n = 1'b0;
  logic        fast_limit_over = 1'b0;
  cpb_req_t    req;
  logic [15:0] rdata;
  logic        rvalid;
  logic [4:0]  crit;
  logic        oc_en, oc_lvl, hs, ls, cle, flt, act;
  logic [15:0] v;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          cnt[4];
  wire  [11:0] outs = {oc_en, oc_lvl, crit, hs, ls, cle, flt, act};
  always #25 clock = ~clock;
  cpb_host cpb_host_inst (.clock(clock), .rvalid(rvalid), .rdata(rdata), .req(req));
  cpb_config #(.RT150_CYC(6), .RT250_CYC(10), .RT50_CYC(2)) cpb_config_inst (
    .clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .battery_present_n(battery_present_n), .fast_limit_over(fast_limit_over),
    .input_overcurrent_enable(oc_en), .input_overcurrent_level(oc_lvl),
    .critical_current_level(crit), .high_side_short_threshold(hs),
    .low_side_short_threshold(ls), .cycle_limit_enable(cle),
    .fast_limit_threshold(flt), .boost_active(act));
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic t_reset;
    cpb_host_inst.rd(8'h37, v);
    chk(v, 16'h0240);
    cpb_host_inst.rd(8'h3c, v);
    chk(v, 16'h4a56);
    chk({4'h0, outs}, 16'h0528);
  endtask
  task automatic t_masks;
    cpb_host_inst.wr(8'h37, 16'hffff);
    cpb_host_inst.rd(8'h37, v);
    chk(v, 16'h06fc);
    chk({4'h0, outs}, 16'h0d3a);
    cpb_host_inst.wr(8'h3c, 16'hffff);
    cpb_host_inst.rd(8'h3c, v);
    chk(v, 16'hfefe);
    chk({11'h000, crit}, 16'h001f);
    cpb_host_inst.rd(8'h00, v);
    chk(v, 16'h0000);
  endtask
  task automatic t_delay;
    for (int s = 0; s < 4; s++)
    begin
      cpb_host_inst.wr(8'h37, 16'h0044 | (16'(s) << 3));
      fast_limit_over = 1'b1;
      cnt[s] = 0;
      while (act !== 1'b1 && cnt[s] < 60)
      begin
        @(negedge clock);
        cnt[s]++;
      end
      chk({15'h0000, cle}, 16'h0001);
      cpb_host_inst.rd(8'h37, v);
      chk(v, 16'h0046 | (16'(s) << 3));
      fast_limit_over = 1'b0;
      repeat (8) @(negedge clock);
      chk({15'h0000, act}, 16'h0000);
    end
    chk(16'(cnt[1] - cnt[0]), 16'h0004);
    chk(16'(cnt[0] - cnt[2]), 16'h0004);
    chk(16'(cnt[3] - cnt[2]), 16'h0000);
  endtask
  task automatic t_removal;
    battery_present_n = 1'b1;
    repeat (8) @(negedge clock);
    cpb_host_inst.rd(8'h37, v);
    chk(v, 16'h0058);
    fast_limit_over = 1'b1;
    repeat (20) @(negedge clock);
    chk({15'h0000, act}, 16'h0000);
    fast_limit_over = 1'b0;
  endtask
  initial
  begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_masks();
    t_delay();
    t_removal();
    conclude();
  end
endmodule
`default_nettype wire
